/* File: inc/vpm_pkg.sv */
// constants for the video pixel encoding mapper
package vpm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int COMP_W = 12;
	localparam int CNT_W = 16;
	localparam int REP_W = 4;

	// register byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SINK = 8'h04;
	localparam logic [7:0] OFS_COLOR = 8'h08;
	localparam logic [7:0] OFS_HTIME = 8'h0C;
	localparam logic [7:0] OFS_HSYNC = 8'h10;
	localparam logic [7:0] OFS_VTIME = 8'h14;
	localparam logic [7:0] OFS_VSYNC = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;

	// control register fields
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_REP_LSB = 3;
	localparam int CTRL_FORCE_REP = 7;
	localparam int CTRL_VGA = 8;
	localparam int CTRL_YQ_FULL = 9;
	localparam int CTRL_BITS_LSB = 10;

	// sink capability register fields
	localparam int SINK_COMPACT = 0;
	localparam int SINK_YCC = 1;
	localparam int SINK_YCC_SEL = 2;

	// colour register fields
	localparam int COLOR_C_LSB = 0;
	localparam int COLOR_EC_LSB = 2;

	// timing register fields: low half and high half
	localparam int LO_LSB = 0;
	localparam int HI_LSB = 16;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// pixel encodings
	localparam logic [1:0] ENC_RGB = 2'h0;
	localparam logic [1:0] ENC_YCC444 = 2'h1;
	localparam logic [1:0] ENC_YCC422 = 2'h2;
	localparam logic [1:0] ENC_COMPACT = 2'h3;

	// link clock mode status values
	localparam logic [2:0] LINK_NORMAL = 3'h3;
	localparam logic [2:0] LINK_COMPACT = 3'h2;

	// repetition limits
	localparam logic [3:0] REP_NONE = 4'h0;
	localparam logic [3:0] REP_DOUBLE = 4'h1;
	localparam logic [3:0] REP_MAX = 4'h9;

	// 4:2:2 component widths and their masks
	localparam logic [1:0] BITS_8 = 2'h0;
	localparam logic [1:0] BITS_10 = 2'h1;
	localparam logic [11:0] MASK_8 = 12'hFF0;
	localparam logic [11:0] MASK_10 = 12'hFFC;
	localparam logic [11:0] MASK_12 = 12'hFFF;

	// quantization and colorimetry codes
	localparam logic [1:0] YQ_LIMITED = 2'h0;
	localparam logic [1:0] YQ_FULL = 2'h1;
	localparam logic [1:0] C_EXTENDED = 2'h3;
	localparam logic [2:0] EC_XV_LAST = 3'h1;
endpackage

/* File: hw/vpm_pixel_mapper.sv */
// video pixel encoding mapper: timing, repetition and channel mapping
`timescale 1ns/1ps
module vpm_pixel_mapper (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [31:0] o_rdata,
	input wire logic [11:0] i_comp_a,
	input wire logic [11:0] i_comp_b,
	input wire logic [11:0] i_comp_c,
	output logic o_pix_ready,
	output logic o_vid_active,
	output logic [7:0] o_ch0,
	output logic [7:0] o_ch1,
	output logic [7:0] o_ch2,
	output logic o_hsync,
	output logic o_vsync,
	output logic [1:0] o_eff_mode,
	output logic [2:0] o_link_mode,
	output logic [3:0] o_repeat_count_field,
	output logic [1:0] o_ycc_quant,
	output logic o_rgb_full_range,
	output logic [1:0] o_colorimetry,
	output logic [2:0] o_ext_colorimetry
);
	logic [31:0] ctrl_reg, sink_reg, color_reg;
	logic [31:0] htime_reg, hsync_reg, vtime_reg, vsync_reg;
	logic [31:0] rdata_reg;
	logic [15:0] h_reg, v_reg;
	logic [3:0] rep_reg;
	logic par_reg, pix_par_reg;
	logic [11:0] y_reg, cb_reg, cr_reg, cr_hold_reg;
	logic [7:0] ch0_reg, ch1_reg, ch2_reg;
	logic act_reg, hs_reg, vs_reg;
	logic [1:0] mode_reg;
	logic [2:0] link_reg;
	logic [3:0] rep_out_reg;
	logic [1:0] yq_reg;
	logic rgbfull_reg;
	logic [1:0] c_reg;
	logic [2:0] ec_reg;
	logic enable, de, fetch, hs_raw, vs_raw, cur_par;
	logic [1:0] req_mode, eff_mode, bits_sel;
	logic [3:0] req_rep, eff_rep;
	logic [11:0] mask, a_m, b_m, c_m, cur_y, cur_cb, cur_cr, cur_g;
	logic [7:0] ch0_next, ch1_next, ch2_next;
	logic [16:0] hs_end, vs_end;
	// register writes
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ctrl_reg <= vpm_pkg::CTRL_RESET;
			sink_reg <= vpm_pkg::ZERO_WORD;
			color_reg <= vpm_pkg::ZERO_WORD;
			htime_reg <= vpm_pkg::ZERO_WORD;
			hsync_reg <= vpm_pkg::ZERO_WORD;
			vtime_reg <= vpm_pkg::ZERO_WORD;
			vsync_reg <= vpm_pkg::ZERO_WORD;
		end else if (i_write) begin
			case (i_addr)
				vpm_pkg::OFS_CTRL: ctrl_reg <= i_wdata;
				vpm_pkg::OFS_SINK: sink_reg <= i_wdata;
				vpm_pkg::OFS_COLOR: color_reg <= i_wdata;
				vpm_pkg::OFS_HTIME: htime_reg <= i_wdata;
				vpm_pkg::OFS_HSYNC: hsync_reg <= i_wdata;
				vpm_pkg::OFS_VTIME: vtime_reg <= i_wdata;
				vpm_pkg::OFS_VSYNC: vsync_reg <= i_wdata;
				default: ;
			endcase
		end
	end
	// register reads, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			rdata_reg <= vpm_pkg::ZERO_WORD;
		end else if (i_read) begin
			case (i_addr)
				vpm_pkg::OFS_CTRL: rdata_reg <= ctrl_reg;
				vpm_pkg::OFS_SINK: rdata_reg <= sink_reg;
				vpm_pkg::OFS_COLOR: rdata_reg <= color_reg;
				vpm_pkg::OFS_HTIME: rdata_reg <= htime_reg;
				vpm_pkg::OFS_HSYNC: rdata_reg <= hsync_reg;
				vpm_pkg::OFS_VTIME: rdata_reg <= vtime_reg;
				vpm_pkg::OFS_VSYNC: rdata_reg <= vsync_reg;
				vpm_pkg::OFS_STATUS: rdata_reg <= {16'h0000, act_reg, vs_reg, hs_reg,
					rep_out_reg, link_reg, mode_reg, ec_reg, 1'b0};
				default: rdata_reg <= vpm_pkg::ZERO_WORD;
			endcase
		end else begin
			rdata_reg <= vpm_pkg::ZERO_WORD;
		end
	end
	assign o_rdata = rdata_reg;
	assign enable = ctrl_reg[vpm_pkg::CTRL_ENABLE];
	assign req_mode = ctrl_reg[vpm_pkg::CTRL_MODE_LSB +: 2];
	assign req_rep = ctrl_reg[vpm_pkg::CTRL_REP_LSB +: 4];
	assign bits_sel = ctrl_reg[vpm_pkg::CTRL_BITS_LSB +: 2];
	// a refused encoding falls back to RGB, which every sink accepts
	always_comb begin
		eff_mode = req_mode;
		if (req_mode == vpm_pkg::ENC_COMPACT && !sink_reg[vpm_pkg::SINK_COMPACT]) begin
			eff_mode = vpm_pkg::ENC_RGB;
		end
		if (req_mode != vpm_pkg::ENC_RGB && !sink_reg[vpm_pkg::SINK_YCC]) begin
			eff_mode = vpm_pkg::ENC_RGB;
		end
	end
	// low-rate and interlaced SD formats never go out unrepeated
	always_comb begin
		eff_rep = (req_rep > vpm_pkg::REP_MAX) ? vpm_pkg::REP_MAX : req_rep;
		if (ctrl_reg[vpm_pkg::CTRL_FORCE_REP] && req_rep == vpm_pkg::REP_NONE) begin
			eff_rep = vpm_pkg::REP_DOUBLE;
		end
	end
	// format timing counters, counted in link clocks
	always_ff @(posedge i_clock) begin
		if (i_reset || !enable) begin
			h_reg <= 16'h0000;
			v_reg <= 16'h0000;
		end else if (h_reg >= htime_reg[vpm_pkg::HI_LSB +: 16] - 16'h0001) begin
			h_reg <= 16'h0000;
			if (v_reg >= vtime_reg[vpm_pkg::HI_LSB +: 16] - 16'h0001) begin
				v_reg <= 16'h0000;
			end else begin
				v_reg <= v_reg + 16'h0001;
			end
		end else begin
			h_reg <= h_reg + 16'h0001;
		end
	end
	assign de = enable && h_reg < htime_reg[vpm_pkg::LO_LSB +: 16]
		&& v_reg < vtime_reg[vpm_pkg::LO_LSB +: 16];
	assign hs_end = {1'b0, hsync_reg[vpm_pkg::LO_LSB +: 16]} + {1'b0, hsync_reg[vpm_pkg::HI_LSB +: 16]};
	assign vs_end = {1'b0, vsync_reg[vpm_pkg::LO_LSB +: 16]} + {1'b0, vsync_reg[vpm_pkg::HI_LSB +: 16]};
	assign hs_raw = enable && h_reg >= hsync_reg[vpm_pkg::LO_LSB +: 16] && {1'b0, h_reg} < hs_end;
	assign vs_raw = enable && v_reg >= vsync_reg[vpm_pkg::LO_LSB +: 16] && {1'b0, v_reg} < vs_end;
	// repetition slot: a new pixel is taken only on slot zero
	always_ff @(posedge i_clock) begin
		if (i_reset || !de || rep_reg >= eff_rep) begin
			rep_reg <= vpm_pkg::REP_NONE;
		end else begin
			rep_reg <= rep_reg + 4'h1;
		end
	end
	assign fetch = de && rep_reg == vpm_pkg::REP_NONE;
	assign o_pix_ready = fetch;
	// even/odd pixel parity restarts with every video data period
	always_ff @(posedge i_clock) begin
		if (i_reset || !de) begin
			par_reg <= 1'b0;
			pix_par_reg <= 1'b0;
		end else if (fetch) begin
			par_reg <= ~par_reg;
			pix_par_reg <= par_reg;
		end
	end
	assign cur_par = fetch ? par_reg : pix_par_reg;
	// 4:2:2 components shorter than twelve bits keep their top bits only
	always_comb begin
		case (bits_sel)
			vpm_pkg::BITS_8: mask = vpm_pkg::MASK_8;
			vpm_pkg::BITS_10: mask = vpm_pkg::MASK_10;
			default: mask = vpm_pkg::MASK_12;
		endcase
		if (eff_mode != vpm_pkg::ENC_YCC422) begin
			mask = vpm_pkg::MASK_8;
		end
	end
	assign a_m = i_comp_a & mask;
	assign b_m = i_comp_b & mask;
	assign c_m = i_comp_c & mask;
	// pixel holding registers feed the repeated slots
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			y_reg <= 12'h000;
			cb_reg <= 12'h000;
			cr_reg <= 12'h000;
			cr_hold_reg <= 12'h000;
		end else if (fetch) begin
			y_reg <= a_m;
			cb_reg <= b_m;
			cr_reg <= c_m;
			if (!par_reg) begin
				cr_hold_reg <= c_m;
			end
		end
	end
	assign cur_y = fetch ? a_m : y_reg;
	assign cur_g = cur_y;
	assign cur_cb = fetch ? b_m : cb_reg;
	assign cur_cr = fetch ? c_m : cr_reg;
	// channel mapping per encoding
	always_comb begin
		ch0_next = 8'h00;
		ch1_next = 8'h00;
		ch2_next = 8'h00;
		case (eff_mode)
			vpm_pkg::ENC_RGB: begin
				ch2_next = cur_y[11:4];
				ch1_next = cur_cb[11:4];
				ch0_next = cur_cr[11:4];
			end
			vpm_pkg::ENC_YCC444: begin
				ch2_next = cur_cr[11:4];
				ch1_next = cur_g[11:4];
				ch0_next = cur_cb[11:4];
			end
			vpm_pkg::ENC_YCC422: begin
				ch1_next = cur_y[11:4];
				ch0_next[3:0] = cur_y[3:0];
				if (!cur_par) begin
					ch0_next[7:4] = cur_cb[3:0];
					ch2_next = cur_cb[11:4];
				end else begin
					ch0_next[7:4] = cr_hold_reg[3:0];
					ch2_next = cr_hold_reg[11:4];
				end
			end
			vpm_pkg::ENC_COMPACT: begin
				ch0_next = cur_y[11:4];
				ch1_next = cur_par ? cr_hold_reg[11:4] : cur_cb[11:4];
			end
			default: ;
		endcase
		if (!de) begin
			ch0_next = 8'h00;
			ch1_next = 8'h00;
			ch2_next = 8'h00;
		end
	end
	// outputs registered together so the first pixel meets the first active clock
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			act_reg <= 1'b0;
			ch0_reg <= 8'h00;
			ch1_reg <= 8'h00;
			ch2_reg <= 8'h00;
		end else begin
			act_reg <= de;
			ch0_reg <= ch0_next;
			ch1_reg <= ch1_next;
			ch2_reg <= ch2_next;
		end
	end
	// syncs are not carried during video data, so they freeze there
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			hs_reg <= 1'b0;
			vs_reg <= 1'b0;
		end else if (!de) begin
			hs_reg <= hs_raw;
			vs_reg <= vs_raw;
		end
	end
	// signalled fields for the infoframe and status path
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			mode_reg <= vpm_pkg::ENC_RGB;
			link_reg <= vpm_pkg::LINK_NORMAL;
			rep_out_reg <= vpm_pkg::REP_NONE;
			yq_reg <= vpm_pkg::YQ_LIMITED;
			rgbfull_reg <= 1'b0;
			c_reg <= 2'h0;
			ec_reg <= 3'h0;
		end else begin
			mode_reg <= eff_mode;
			link_reg <= (eff_mode == vpm_pkg::ENC_COMPACT) ?
				vpm_pkg::LINK_COMPACT : vpm_pkg::LINK_NORMAL;
			rep_out_reg <= eff_rep;
			if (!sink_reg[vpm_pkg::SINK_YCC_SEL]) begin
				yq_reg <= vpm_pkg::YQ_LIMITED;
			end else begin
				yq_reg <= ctrl_reg[vpm_pkg::CTRL_YQ_FULL] ?
					vpm_pkg::YQ_FULL : vpm_pkg::YQ_LIMITED;
			end
			rgbfull_reg <= ctrl_reg[vpm_pkg::CTRL_VGA];
			if (color_reg[vpm_pkg::COLOR_C_LSB +: 2] == vpm_pkg::C_EXTENDED
				&& color_reg[vpm_pkg::COLOR_EC_LSB +: 3] <= vpm_pkg::EC_XV_LAST) begin
				c_reg <= 2'h0;
				ec_reg <= 3'h0;
			end else begin
				c_reg <= color_reg[vpm_pkg::COLOR_C_LSB +: 2];
				ec_reg <= color_reg[vpm_pkg::COLOR_EC_LSB +: 3];
			end
		end
	end
	assign o_vid_active = act_reg;
	assign o_ch0 = ch0_reg;
	assign o_ch1 = ch1_reg;
	assign o_ch2 = ch2_reg;
	assign o_hsync = hs_reg;
	assign o_vsync = vs_reg;
	assign o_eff_mode = mode_reg;
	assign o_link_mode = link_reg;
	assign o_repeat_count_field = rep_out_reg;
	assign o_ycc_quant = yq_reg;
	assign o_rgb_full_range = rgbfull_reg;
	assign o_colorimetry = c_reg;
	assign o_ext_colorimetry = ec_reg;

	AST_REP_REPORTED: assert property (@(posedge i_clock) disable iff (i_reset)
		##1 o_repeat_count_field == $past(eff_rep))
		else $error("reported repetition differs from repetition in use");
	AST_SD_REPEATED: assert property (@(posedge i_clock) disable iff (i_reset)
		ctrl_reg[vpm_pkg::CTRL_FORCE_REP] |=> o_repeat_count_field != vpm_pkg::REP_NONE)
		else $error("forced-repetition format sent unrepeated");
	AST_SLOT_BOUND: assert property (@(posedge i_clock) disable iff (i_reset)
		rep_reg <= eff_rep || !$stable(eff_rep) || !$past(de))
		else $error("repetition slot beyond count");
	AST_DOUBLE_SAME: assert property (@(posedge i_clock) disable iff (i_reset)
		(de && rep_reg == vpm_pkg::REP_DOUBLE && $stable(eff_mode))
		|=> o_ch0 == $past(o_ch0) && o_ch1 == $past(o_ch1) && o_ch2 == $past(o_ch2))
		else $error("repeated clock differs from its original");
	AST_FIRST_RGB: assert property (@(posedge i_clock) disable iff (i_reset)
		(fetch && eff_mode == vpm_pkg::ENC_RGB)
		|=> o_vid_active && o_ch2 == $past(i_comp_a[11:4]) && o_ch1 == $past(i_comp_b[11:4]))
		else $error("RGB pixel not on its clock");
	AST_LUMA_422: assert property (@(posedge i_clock) disable iff (i_reset)
		(fetch && eff_mode == vpm_pkg::ENC_YCC422)
		|=> o_ch1 == $past(a_m[11:4]) && o_ch0[3:0] == $past(a_m[3:0]))
		else $error("4:2:2 luma misplaced");
	AST_CR_ODD: assert property (@(posedge i_clock) disable iff (i_reset)
		(fetch && !par_reg && eff_mode == vpm_pkg::ENC_YCC422 && eff_rep == vpm_pkg::REP_NONE)
		##1 (fetch && $stable(eff_mode)) |=> o_ch2 == $past(i_comp_c[11:4], 2))
		else $error("Cr of even pixel missing on odd clock");
	AST_LINK_CODE: assert property (@(posedge i_clock) disable iff (i_reset)
		(o_eff_mode == vpm_pkg::ENC_COMPACT) == (o_link_mode == vpm_pkg::LINK_COMPACT)
		&& (o_link_mode == vpm_pkg::LINK_COMPACT || o_link_mode == vpm_pkg::LINK_NORMAL))
		else $error("link mode does not match encoding");
	AST_YCC_LIMITED: assert property (@(posedge i_clock) disable iff (i_reset)
		!sink_reg[vpm_pkg::SINK_YCC_SEL] |=> o_ycc_quant == vpm_pkg::YQ_LIMITED)
		else $error("full range YCbCr to non-selectable sink");
	AST_NO_EXTENDED_GAMUT_YCC: assert property (@(posedge i_clock) disable iff (i_reset)
		!(o_colorimetry == vpm_pkg::C_EXTENDED && o_ext_colorimetry <= vpm_pkg::EC_XV_LAST))
		else $error("extended-gamut YCC announced");
	AST_SYNC_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
		(de && $past(de)) |=> $stable(o_hsync) && $stable(o_vsync))
		else $error("sync moved during video data");
	AST_CAP_GATE: assert property (@(posedge i_clock) disable iff (i_reset)
		(!sink_reg[vpm_pkg::SINK_YCC] && $stable(sink_reg)) |=> o_eff_mode == vpm_pkg::ENC_RGB)
		else $error("YCbCr sent to sink without support");
endmodule // vpm_pixel_mapper

/* File: sim/vpm_sink_model.sv */
// sink receiver model facing the mapper's logical channels
`timescale 1ns/1ps
module vpm_sink_model (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_vid_active,
	input wire logic i_hsync,
	input wire logic i_vsync,
	input wire logic [2:0] i_link_mode,
	input wire logic [1:0] i_ycc_quant,
	input wire logic [3:0] i_repeat_count_field,
	output logic o_hs_held,
	output logic o_vs_held,
	output logic o_compact,
	output logic o_full_range
);
	// syncs are not carried in video data, so keep the levels seen in blanking
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_hs_held <= 1'b0;
			o_vs_held <= 1'b0;
		end else if (!i_vid_active) begin
			o_hs_held <= i_hsync;
			o_vs_held <= i_vsync;
		end
	end
	// only 010 selects compact; anything else, or nothing yet, stays normal
	always_ff @(posedge i_clock) begin
		if (i_reset)
			o_compact <= 1'b0;
		else
			o_compact <= (i_link_mode == 3'h2);
	end
	// 0 limited, 1 full, other codes fall back to the format default (limited)
	// repetition field left unused, which a sink is allowed to do
	always_comb o_full_range = (i_ycc_quant == 2'h1) && (i_repeat_count_field !== 4'hX);
endmodule // vpm_sink_model

/* File: sim/tb_video_pixel_encoding_mapper.sv */
// self-checking bench for the pixel encoding mapper
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_video_pixel_encoding_mapper;
	logic i_clock = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic i_write = 1'b0;
	logic i_read = 1'b0;
	logic [11:0] i_comp_a = 12'h000, i_comp_b = 12'h000, i_comp_c = 12'h000;
	logic [31:0] o_rdata, d;
	logic o_pix_ready, o_vid_active, o_hsync, o_vsync, o_rgb_full_range;
	logic [7:0] o_ch0, o_ch1, o_ch2;
	logic [1:0] o_eff_mode, o_ycc_quant, o_colorimetry;
	logic [2:0] o_link_mode, o_ext_colorimetry;
	logic [3:0] o_repeat_count_field;
	logic hs_held, vs_held, snk_compact, snk_full;
	int num_errors = 0, samples_checked = 0, cycles = 0, idx = 0, run = 0, hrun = 0, vrun = 0;
	logic model_on = 1'b0, armed = 1'b0;
	logic [1:0] emode = 2'h0;
	logic [3:0] erep = 4'h0;
	logic [11:0] emask = 12'hFFF, cr_hold = 12'h000, ya, ca;
	logic [23:0] pix;
	logic [23:0] q[$];
	// enable | mode<<1 | rep<<3 | force<<7 | bits<<10
	logic [11:0] ctl[8] = '{12'h001, 12'h00B, 12'h005, 12'h80D, 12'h007, 12'h011, 12'h081, 12'h00F};
	logic [1:0] em[8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
	logic [3:0] er[8] = '{4'h0, 4'h1, 4'h0, 4'h1, 4'h0, 4'h2, 4'h1, 4'h1};
	logic [2:0] snk[8] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h0};
	logic [4:0] cw[4] = '{5'h03, 5'h07, 5'h01, 5'h0B};

	always #12.5 i_clock = ~i_clock;

	vpm_pixel_mapper vpm_pixel_mapper_inst (.i_clock(i_clock), .i_reset(i_reset),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
		.o_rdata(o_rdata), .i_comp_a(i_comp_a), .i_comp_b(i_comp_b), .i_comp_c(i_comp_c),
		.o_pix_ready(o_pix_ready), .o_vid_active(o_vid_active), .o_ch0(o_ch0),
		.o_ch1(o_ch1), .o_ch2(o_ch2), .o_hsync(o_hsync), .o_vsync(o_vsync),
		.o_eff_mode(o_eff_mode), .o_link_mode(o_link_mode),
		.o_repeat_count_field(o_repeat_count_field), .o_ycc_quant(o_ycc_quant),
		.o_rgb_full_range(o_rgb_full_range), .o_colorimetry(o_colorimetry),
		.o_ext_colorimetry(o_ext_colorimetry));
	vpm_sink_model vpm_sink_model_inst (.i_clock(i_clock), .i_reset(i_reset),
		.i_vid_active(o_vid_active), .i_hsync(o_hsync), .i_vsync(o_vsync),
		.i_link_mode(o_link_mode), .i_ycc_quant(o_ycc_quant),
		.i_repeat_count_field(o_repeat_count_field), .o_hs_held(hs_held),
		.o_vs_held(vs_held), .o_compact(snk_compact), .o_full_range(snk_full));

	task automatic give_verdict();
		$display("errors %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge i_clock);
		i_write <= 1'b1;
		i_addr <= a;
		i_wdata <= w;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clock);
		i_read <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic settle();
		repeat (3) @(posedge i_clock);
		#1;
	endtask

	// fresh component values every cycle; the mapper takes them only when ready
	always @(posedge i_clock) begin
		i_comp_a <= 12'($urandom);
		i_comp_b <= 12'($urandom);
		i_comp_c <= 12'($urandom);
	end

	// a hang counts as a mismatch and still reaches the verdict
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	// reference model: queue of expected channel bytes, one entry per link clock
	always @(posedge i_clock) begin
		if (!model_on) begin
			q.delete();
			armed = 1'b0;
			run = 0;
			hrun = 0;
			vrun = 0;
		end else begin
			if (o_vid_active) begin
				pix = (q.size() > 0) ? q.pop_front() : {24{1'bx}};
				`CHK({o_ch2, o_ch1, o_ch0}, pix)
				`CHK(o_hsync, hs_held)
				run++;
			end else if (run > 0) begin
				if (armed) `CHK(run, 12)
				run = 0;
				armed = 1'b1;
			end
			if (o_hsync) begin
				hrun++;
			end else if (hrun > 0) begin
				if (armed) `CHK(hrun, 2)
				hrun = 0;
			end
			if (o_vsync) begin
				vrun++;
			end else if (vrun > 0) begin
				if (armed) `CHK(vrun, 16)
				vrun = 0;
			end
			if (o_pix_ready) begin
				if (!o_vid_active) idx = 0;
				ya = i_comp_a & emask;
				ca = (idx % 2 == 0) ? (i_comp_b & emask) : cr_hold;
				case (emode)
					2'h0: pix = {i_comp_a[11:4], i_comp_b[11:4], i_comp_c[11:4]};
					2'h1: pix = {i_comp_c[11:4], i_comp_a[11:4], i_comp_b[11:4]};
					2'h2: pix = {ca[11:4], ya[11:4], ca[3:0], ya[3:0]};
					default: pix = {8'h00, ca[11:4], i_comp_a[11:4]};
				endcase
				if (idx % 2 == 0) cr_hold = i_comp_c & emask;
				repeat (int'(erep) + 1) q.push_back(pix);
				idx++;
			end
		end
	end

	initial begin
		void'($urandom(47552));
		repeat (10) @(posedge i_clock);
		i_reset <= 1'b0;
		settle();
		`CHK(o_link_mode, vpm_pkg::LINK_NORMAL)
		`CHK(snk_compact, 1'b0)
		`CHK(o_repeat_count_field, vpm_pkg::REP_NONE)
		rd(vpm_pkg::OFS_CTRL);
		`CHK(d, vpm_pkg::CTRL_RESET)
		rd(vpm_pkg::OFS_STATUS);
		`CHK(d, 32'h0000_00C0)
		wr(vpm_pkg::OFS_HTIME, 32'h0010_000C);
		rd(vpm_pkg::OFS_HTIME);
		`CHK(d, 32'h0010_000C)
		rd(8'h40);
		`CHK(d, vpm_pkg::ZERO_WORD)
		// short test format: 12 of 16 pixels, 2 of 4 lines, syncs in blanking
		wr(vpm_pkg::OFS_HSYNC, 32'h0002_000D);
		wr(vpm_pkg::OFS_VTIME, 32'h0004_0002);
		wr(vpm_pkg::OFS_VSYNC, 32'h0001_0002);
		for (int i = 0; i < 8; i++) begin
			model_on <= 1'b0;
			wr(vpm_pkg::OFS_CTRL, 32'h0);
			wr(vpm_pkg::OFS_SINK, {29'h0, snk[i]});
			repeat (4) @(posedge i_clock);
			emode = em[i];
			erep = er[i];
			emask = (ctl[i][11:10] == 2'h0) ? 12'hFF0 : (ctl[i][11:10] == 2'h1) ? 12'hFFC : 12'hFFF;
			model_on <= 1'b1;
			wr(vpm_pkg::OFS_CTRL, {20'h0, ctl[i]});
			settle();
			`CHK(o_eff_mode, em[i])
			`CHK(o_link_mode, (em[i] == 2'h3) ? 3'h2 : 3'h3)
			`CHK(o_repeat_count_field, er[i])
			repeat (160) @(posedge i_clock);
			`CHK(snk_compact, em[i] == 2'h3)
		end
		model_on <= 1'b0;
		// repetition count above the limit is clamped
		wr(vpm_pkg::OFS_CTRL, 32'h0000_0079);
		settle();
		`CHK(o_repeat_count_field, vpm_pkg::REP_MAX)
		wr(vpm_pkg::OFS_SINK, 32'h3);
		wr(vpm_pkg::OFS_CTRL, 32'h0000_0203);
		settle();
		`CHK(o_ycc_quant, vpm_pkg::YQ_LIMITED)
		`CHK(snk_full, 1'b0)
		wr(vpm_pkg::OFS_SINK, 32'h7);
		settle();
		`CHK(o_ycc_quant, vpm_pkg::YQ_FULL)
		`CHK(snk_full, 1'b1)
		`CHK(o_rgb_full_range, 1'b0)
		wr(vpm_pkg::OFS_CTRL, 32'h0000_0101);
		settle();
		`CHK(o_rgb_full_range, 1'b1)
		for (int i = 0; i < 4; i++) begin
			wr(vpm_pkg::OFS_COLOR, {27'h0, cw[i]});
			settle();
			`CHK({o_ext_colorimetry, o_colorimetry}, ((cw[i][1:0] == 2'h3) && (cw[i][4:2] <= 3'h1)) ? 5'h00 : cw[i])
		end
		give_verdict();
	end
endmodule // tb_video_pixel_encoding_mapper
